// ==== verilog/silog_pkg.sv ====
// package: register map, field layout and timing constants of the status input logger
package silog_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_PERIOD_NS = 1_000_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned SAMPLE_DIV = 100;
    localparam logic [15:0] FRAC_FULL = 16'h2710;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PERIOD = 8'h04;
    localparam logic [7:0] ADDR_THRESH = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_DATA = 8'h10;
    localparam logic [7:0] ADDR_ACCUM = 8'h14;

    // control fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_INV = 1;
    localparam int CTRL_MODE_LO = 2;
    localparam int CTRL_MODE_HI = 3;
    localparam int CTRL_TRIG_LO = 4;
    localparam int CTRL_TRIG_HI = 5;
    localparam int CTRL_PIN = 6;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] PERIOD_RESET = 32'h0000_012C;
    localparam logic [31:0] THRESH_RESET = 32'h0000_0000;

    // status fields
    localparam int ST_RAW = 0;
    localparam int ST_TRIG = 1;
    localparam int ST_PIN0 = 2;
    localparam int ST_PIN1 = 3;
    localparam int ST_VALID = 4;

    typedef enum logic [1:0] {
        SILOG_MODE_LEVEL = 2'h0,
        SILOG_MODE_TIMEON = 2'h1,
        SILOG_MODE_FRAC = 2'h2
    } silog_mode_t;

    typedef enum logic [1:0] {
        SILOG_TRIG_RISE = 2'h0,
        SILOG_TRIG_ABOVE = 2'h1,
        SILOG_TRIG_BELOW = 2'h2,
        SILOG_TRIG_OFF = 2'h3
    } silog_trig_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } silog_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } silog_apb_rsp_t;
endpackage

// ==== verilog/silog_top.sv ====
// status input logger: switch sampling, datapoint generation, triggers, apb registers
// Summary of operation
// RULE_01: level mode logs one bit per period, sampled level, 1 for closed.
// RULE_02: inverted channel processes input identically but complements each logged datapoint.
// RULE_03: hardware test readout shows raw synchronised level, ignoring inversion and mode.
// RULE_04: time-on mode counts whole seconds closed since last datapoint and logs it.
// RULE_05: seconds counter clears right after each datapoint is produced.
// RULE_06: inverted channel in time-on mode counts seconds open instead.
// RULE_07: time-on datapoint never exceeds the period length in seconds.
// RULE_08: proportion mode logs fraction of period in chosen state, scaled 0 to 10000.
// RULE_09: closed-fraction: 0 means always open, 10000 always closed; open-fraction reversed.
// RULE_10: triggers compare the logged datapoint after inversion, never the raw level.
// RULE_11: level trigger asserts at first boundary where logged value goes 0 to 1.
// RULE_12: level alarm deasserts at the boundary where logged value returns to 0.
// RULE_13: software keeps thresholds inside each stream's reachable range.
// RULE_14: status use claims exactly one pin of the two-pin pulse pair.
// RULE_15: input is sampled far faster than the log period to measure durations.
// RULE_16: one-second tick and log-boundary strobe derive from the system clock.
// RULE_17: switch input passes synchronising flip-flops before any sampling or counting.
`timescale 1ns/1ns
module silog_top
    import silog_pkg::*;
#(
    parameter int unsigned TICK_CYC = TICK_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pulse pin pair
    input wire logic [1:0] pulse_pin,
    // results
    output logic [15:0] datapoint,
    output logic datapoint_valid,
    output logic trigger_active,
    output logic [1:0] pin_claim
);
    typedef struct packed {
        logic [2:0] sync;
        logic level;
        logic [31:0] ctrl;
        logic [31:0] period;
        logic [15:0] thresh;
        logic [26:0] tick_cnt;
        logic [6:0] samp_cnt;
        logic [31:0] sec_cnt;
        logic [15:0] on_secs;
        logic [31:0] on_samp;
        logic [31:0] tot_samp;
        logic [15:0] data;
        logic dvalid;
        logic prev_bit;
        logic trig;
        logic [31:0] rdata;
        logic [15:0] frac;
        logic fbusy;
        logic [4:0] fstep;
        logic [47:0] frem;
        logic [31:0] fden;
    } silog_state_t;

    silog_state_t s_r;
    silog_state_t s_nxt;

    silog_apb_req_t req;
    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    logic tick;
    logic samp_en;
    logic boundary;
    logic chosen;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [15:0] logged;
    logic [15:0] secs_cap;
    logic [16:0] secs_sum;
    silog_mode_t mode;
    silog_trig_t trig_kind;

    assign mode = silog_mode_t'(s_r.ctrl[CTRL_MODE_HI:CTRL_MODE_LO]);
    assign trig_kind = silog_trig_t'(s_r.ctrl[CTRL_TRIG_HI:CTRL_TRIG_LO]);
    assign tick = s_r.ctrl[CTRL_EN] && (s_r.tick_cnt == 27'(TICK_CYC - 1)); // RULE_16
    assign samp_en = s_r.ctrl[CTRL_EN] && (s_r.samp_cnt == 7'(SAMPLE_DIV - 1)); // RULE_15
    assign boundary = tick && (s_r.sec_cnt + 32'h1 >= s_r.period); // RULE_16
    // time-based modes count the chosen state; inversion flips what counts as chosen
    assign chosen = s_r.level ^ s_r.ctrl[CTRL_INV]; // RULE_06 RULE_09
    assign addr_ok = (req.paddr <= ADDR_ACCUM) && (req.paddr[1:0] == 2'h0);
    assign wr_en = req.psel && req.penable && req.pwrite && addr_ok;
    assign rd_en = req.psel && !req.penable && !req.pwrite;
    // the boundary tick's own second belongs to the period that it closes
    assign secs_sum = {1'b0, s_r.on_secs} + {16'h0, tick && chosen}; // RULE_04 RULE_06
    // hold seconds at the period length even if period shrank mid-period
    assign secs_cap = ({15'h0, secs_sum} > s_r.period) ? s_r.period[15:0]
        : (secs_sum[16] ? 16'hFFFF : secs_sum[15:0]); // RULE_07

    always_comb begin
        logged = 16'h0;
        unique case (mode)
            SILOG_MODE_LEVEL: logged = {15'h0, chosen}; // RULE_01 RULE_02
            SILOG_MODE_TIMEON: logged = secs_cap; // RULE_04 RULE_06
            default: logged = 16'h0;
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.dvalid = 1'b0;
        // three-stage synchroniser; level changes once stages two and three agree
        s_nxt.sync = {s_r.sync[1:0], pulse_pin[s_r.ctrl[CTRL_PIN]]}; // RULE_17 RULE_14
        if (s_r.sync[2] == s_r.sync[1]) begin
            s_nxt.level = s_r.sync[2]; // RULE_17
        end
        s_nxt.tick_cnt = tick || !s_r.ctrl[CTRL_EN] ? 27'h0 : s_r.tick_cnt + 27'h1;
        s_nxt.samp_cnt = samp_en || !s_r.ctrl[CTRL_EN] ? 7'h0 : s_r.samp_cnt + 7'h1;
        if (samp_en) begin
            s_nxt.tot_samp = s_r.tot_samp + 32'h1; // RULE_15
            s_nxt.on_samp = s_r.on_samp + {31'h0, chosen}; // RULE_08
        end
        if (tick) begin
            s_nxt.sec_cnt = s_r.sec_cnt + 32'h1;
            if (chosen && s_r.on_secs != 16'hFFFF) begin
                s_nxt.on_secs = s_r.on_secs + 16'h1; // RULE_04
            end
        end
        if (boundary) begin
            s_nxt.sec_cnt = 32'h0;
            s_nxt.on_secs = 16'h0; // RULE_05
            s_nxt.on_samp = 32'h0;
            s_nxt.tot_samp = 32'h0;
            s_nxt.prev_bit = logged[0];
            if (mode == SILOG_MODE_FRAC) begin
                // sequential divide keeps the datapath small; result lands 18 cycles later
                s_nxt.fbusy = 1'b1;
                s_nxt.fstep = 5'h0;
                s_nxt.frem = 48'(s_r.on_samp + {31'h0, samp_en && chosen}) * 48'(FRAC_FULL);
                s_nxt.fden = s_r.tot_samp + {31'h0, samp_en};
                s_nxt.frac = 16'h0;
            end else begin
                s_nxt.data = logged;
                s_nxt.dvalid = 1'b1;
                unique case (trig_kind)
                    // level stream: set on logged rise, clear when logged value returns to 0
                    SILOG_TRIG_RISE: s_nxt.trig = logged[0] && (!s_r.prev_bit || s_r.trig); // RULE_11 RULE_12 RULE_10
                    SILOG_TRIG_ABOVE: s_nxt.trig = logged > s_r.thresh; // RULE_10 RULE_13
                    SILOG_TRIG_BELOW: s_nxt.trig = logged < s_r.thresh; // RULE_10
                    SILOG_TRIG_OFF: s_nxt.trig = 1'b0;
                endcase
            end
        end
        if (s_r.fbusy) begin
            // restoring division of frem by fden, sixteen quotient bits
            if (s_r.fstep == 5'h10) begin
                s_nxt.fbusy = 1'b0;
                s_nxt.data = (s_r.frac > FRAC_FULL) ? FRAC_FULL : s_r.frac; // RULE_08 RULE_09
                s_nxt.dvalid = 1'b1;
                unique case (trig_kind)
                    SILOG_TRIG_ABOVE: s_nxt.trig = s_r.frac > s_r.thresh; // RULE_10
                    SILOG_TRIG_BELOW: s_nxt.trig = s_r.frac < s_r.thresh; // RULE_10
                    default: s_nxt.trig = 1'b0;
                endcase
            end else begin
                s_nxt.fstep = s_r.fstep + 5'h1;
                if (s_r.fden == 32'h0) begin
                    s_nxt.frac = 16'h0;
                end else if (s_r.frem >= (48'(s_r.fden) << (5'hF - s_r.fstep))) begin
                    s_nxt.frem = s_r.frem - (48'(s_r.fden) << (5'hF - s_r.fstep));
                    s_nxt.frac = s_r.frac | (16'h8000 >> s_r.fstep[3:0]);
                end
            end
        end
        if (wr_en) begin
            unique case (req.paddr)
                ADDR_CTRL: s_nxt.ctrl = {25'h0, req.pwdata[6:0]};
                ADDR_PERIOD: s_nxt.period = (req.pwdata == 32'h0) ? 32'h1 : req.pwdata;
                ADDR_THRESH: s_nxt.thresh = req.pwdata[15:0];
                default: s_nxt.ctrl = s_nxt.ctrl;
            endcase
        end
        if (rd_en) begin
            unique case (req.paddr)
                ADDR_CTRL: s_nxt.rdata = s_r.ctrl;
                ADDR_PERIOD: s_nxt.rdata = s_r.period;
                ADDR_THRESH: s_nxt.rdata = {16'h0, s_r.thresh};
                ADDR_STATUS: s_nxt.rdata = {27'h0, s_r.fbusy, pin_claim, s_r.trig, s_r.level}; // RULE_03
                ADDR_DATA: s_nxt.rdata = {16'h0, s_r.data};
                ADDR_ACCUM: s_nxt.rdata = {16'h0, s_r.on_secs};
                default: s_nxt.rdata = 32'h0;
            endcase
        end
        if (!s_r.ctrl[CTRL_EN]) begin
            s_nxt.sec_cnt = 32'h0;
            s_nxt.on_secs = 16'h0;
            s_nxt.on_samp = 32'h0;
            s_nxt.tot_samp = 32'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RESET;
            s_r.period <= PERIOD_RESET;
            s_r.thresh <= THRESH_RESET[15:0];
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.rdata;
    assign pready = 1'b1;
    assign pslverr = req.psel && req.penable && !addr_ok;
    assign datapoint = s_r.data;
    assign datapoint_valid = s_r.dvalid;
    assign trigger_active = s_r.trig;
    // only the selected pin of the pair is claimed while enabled
    assign pin_claim = s_r.ctrl[CTRL_EN] ? (s_r.ctrl[CTRL_PIN] ? 2'h2 : 2'h1) : 2'h0; // RULE_14

    // level-mode datapoint is the inverted-or-not synchronised level
    property p_level_dp;
        @(posedge mclk) disable iff (!rstn)
        (boundary && mode == SILOG_MODE_LEVEL) |=> datapoint_valid
            && datapoint == {15'h0, $past(s_r.level) ^ $past(s_r.ctrl[CTRL_INV])};
    endproperty
    a_level_dp: assert property (p_level_dp) else $error("level datapoint wrong"); // RULE_01

    property p_inv_dp;
        @(posedge mclk) disable iff (!rstn)
        (boundary && mode == SILOG_MODE_LEVEL && s_r.ctrl[CTRL_INV]) |=> datapoint[0] != $past(s_r.level);
    endproperty
    a_inv_dp: assert property (p_inv_dp) else $error("inversion not applied"); // RULE_02

    property p_raw;
        @(posedge mclk) disable iff (!rstn)
        (rd_en && paddr == ADDR_STATUS) |=> prdata[ST_RAW] == $past(s_r.level);
    endproperty
    a_raw: assert property (p_raw) else $error("raw readout not raw level"); // RULE_03

    property p_clear;
        @(posedge mclk) disable iff (!rstn)
        boundary |=> s_r.on_secs == 16'h0 && s_r.sec_cnt == 32'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("counter not cleared"); // RULE_05

    property p_count;
        @(posedge mclk) disable iff (!rstn)
        (tick && !boundary && chosen && s_r.on_secs < 16'hFFFF) |=> s_r.on_secs == $past(s_r.on_secs) + 16'h1;
    endproperty
    a_count: assert property (p_count) else $error("second not counted"); // RULE_04

    property p_cap;
        @(posedge mclk) disable iff (!rstn)
        (boundary && mode == SILOG_MODE_TIMEON) |=> datapoint <= $past(s_r.period[15:0]);
    endproperty
    a_cap: assert property (p_cap) else $error("time-on above period"); // RULE_07

    property p_frac;
        @(posedge mclk) disable iff (!rstn)
        (boundary && mode == SILOG_MODE_FRAC) |-> ##[1:20] (datapoint_valid && datapoint <= FRAC_FULL);
    endproperty
    a_frac: assert property (p_frac) else $error("fraction missing or out of range"); // RULE_08

    property p_rise;
        @(posedge mclk) disable iff (!rstn)
        (boundary && mode == SILOG_MODE_LEVEL && trig_kind == SILOG_TRIG_RISE
            && logged[0] && !s_r.prev_bit) |=> trigger_active;
    endproperty
    a_rise: assert property (p_rise) else $error("rise trigger missed"); // RULE_11

    property p_fall;
        @(posedge mclk) disable iff (!rstn)
        (boundary && mode == SILOG_MODE_LEVEL && trig_kind == SILOG_TRIG_RISE && !logged[0])
            |=> !trigger_active;
    endproperty
    a_fall: assert property (p_fall) else $error("alarm not cleared"); // RULE_12

    property p_claim;
        @(posedge mclk) disable iff (!rstn)
        s_r.ctrl[CTRL_EN] |-> $onehot(pin_claim);
    endproperty
    a_claim: assert property (p_claim) else $error("pin claim not one pin"); // RULE_14

    // the level follows the synchroniser only once its last two stages agree
    property p_sync;
        @(posedge mclk) disable iff (!rstn)
        !$stable(s_r.level) |-> $past(s_r.sync[2]) == $past(s_r.sync[1])
            && s_r.level == $past(s_r.sync[2]);
    endproperty
    a_sync: assert property (p_sync) else $error("level moved before sync settled"); // RULE_17

    // triggers move only together with a fresh datapoint
    property p_trig_dp;
        @(posedge mclk) disable iff (!rstn)
        !$stable(trigger_active) |-> datapoint_valid;
    endproperty
    a_trig_dp: assert property (p_trig_dp) else $error("trigger moved off a datapoint"); // RULE_10

    property p_idle;
        @(posedge mclk) disable iff (!rstn)
        (!s_r.ctrl[CTRL_EN] && !s_r.fbusy) |=> !datapoint_valid;
    endproperty
    a_idle: assert property (p_idle) else $error("datapoint while disabled"); // RULE_16

    property p_frac_lat;
        @(posedge mclk) disable iff (!rstn)
        (boundary && mode == SILOG_MODE_FRAC) |-> ##18 datapoint_valid;
    endproperty
    a_frac_lat: assert property (p_frac_lat) else $error("fraction latency wrong"); // RULE_08

    // a period spent wholly in the chosen state must give the full scale
    property p_frac_full;
        @(posedge mclk) disable iff (!rstn)
        (boundary && mode == SILOG_MODE_FRAC && s_r.tot_samp != 32'h0
            && s_r.on_samp == s_r.tot_samp && (chosen || !samp_en)) |-> ##18 datapoint == FRAC_FULL;
    endproperty
    a_frac_full: assert property (p_frac_full) else $error("full fraction wrong"); // RULE_09

    property p_frac_zero;
        @(posedge mclk) disable iff (!rstn)
        (boundary && mode == SILOG_MODE_FRAC && s_r.on_samp == 32'h0 && !(samp_en && chosen))
            |-> ##18 datapoint == 16'h0;
    endproperty
    a_frac_zero: assert property (p_frac_zero) else $error("empty fraction not zero"); // RULE_09

    property p_inv_count;
        @(posedge mclk) disable iff (!rstn)
        (tick && !boundary && s_r.ctrl[CTRL_INV] && !s_r.level && s_r.on_secs < 16'hFFFF)
            |=> s_r.on_secs == $past(s_r.on_secs) + 16'h1;
    endproperty
    a_inv_count: assert property (p_inv_count) else $error("open second not counted"); // RULE_06

    property p_hold;
        @(posedge mclk) disable iff (!rstn)
        (tick && !boundary && !chosen) |=> s_r.on_secs == $past(s_r.on_secs);
    endproperty
    a_hold: assert property (p_hold) else $error("second counted in wrong state"); // RULE_04
endmodule

// ==== testbench/silog_switch_model.sv ====
// switch contact model driving one pin of the pulse pin pair
`timescale 1ns/1ns
module silog_switch_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // contact setting
    input wire logic closed,
    input wire logic pin_sel,
    // pin pair
    output logic [1:0] pulse_pin
);
    logic chatter_r;

    // the unused pin never rests, so claiming the wrong pin shows up at once
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            chatter_r <= 1'b0;
        end else begin
            chatter_r <= ~chatter_r;
        end
    end

    assign pulse_pin = pin_sel ? {closed, chatter_r} : {chatter_r, closed};
endmodule

// ==== testbench/tb_status_input_logger.sv ====
// self-checking bench of the status input logger
`timescale 1ns/1ns
module tb_status_input_logger
    import silog_pkg::*;
;
    // short second keeps the run small
    localparam int unsigned TICKS = 20;
    localparam logic [15:0] PER = 16'h000A;
    logic mclk, rstn, psel, penable, pwrite, closed, pin_sel;
    logic pready, pslverr, err, dv, trig_act, tr;
    logic last_bit, last_trig;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [1:0] pulse_pin, pin_claim;
    logic [15:0] datapoint, dp, th;
    int errors, samples_checked;

    silog_top #(.TICK_CYC(TICKS)) dut_u (.mclk(mclk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pulse_pin(pulse_pin), .datapoint(datapoint),
        .datapoint_valid(dv), .trigger_active(trig_act), .pin_claim(pin_claim));
    silog_switch_model sw_u (.mclk(mclk), .rstn(rstn), .closed(closed), .pin_sel(pin_sel),
        .pulse_pin(pulse_pin));

    task automatic tally_and_finish();
        if (errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic tmo;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        tmo = (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
        if (tmo) begin
            errors++;
            tally_and_finish();
        end
    endtask

    task automatic wait_dp();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (dv !== 1'b1 && n < 2000);
        dp = datapoint;
        tr = trig_act;
        if (dv !== 1'b1) begin
            errors++;
            tally_and_finish();
        end
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [15:0] exp_dp(input logic [1:0] m, input logic on);
        if (m == SILOG_MODE_TIMEON) begin
            return on ? PER : 16'h0000;
        end
        if (m == SILOG_MODE_FRAC) begin
            return on ? FRAC_FULL : 16'h0000;
        end
        return {15'h0000, on};
    endfunction

    function automatic logic exp_trig(input logic [1:0] t, input logic [15:0] v,
        input logic [15:0] h);
        case (t)
            SILOG_TRIG_RISE: return v == 16'h0001;
            SILOG_TRIG_ABOVE: return v > h;
            SILOG_TRIG_BELOW: return v < h;
            default: return 1'b0;
        endcase
    endfunction

    // first datapoint after a change straddles it, so only the second is judged
    task automatic run(input logic [1:0] m, input logic inv, input logic [1:0] t,
        input logic lvl, input logic ps);
        logic on;
        logic [15:0] ev;
        logic etr;
        on = lvl ^ inv;
        if (m != SILOG_MODE_LEVEL && t == SILOG_TRIG_RISE) begin
            t = SILOG_TRIG_OFF;
        end
        th = (m == SILOG_MODE_LEVEL) ? 16'h0000 : (m == SILOG_MODE_TIMEON) ? 16'h0005 : 16'h1388;
        closed <= lvl;
        pin_sel <= ps;
        apb(1'b1, ADDR_THRESH, {16'h0000, th});
        apb(1'b1, ADDR_CTRL, {25'h0000000, ps, t, m, inv, 1'b1});
        chk("pin_claim", ps ? 2'h2 : 2'h1, pin_claim);
        // a newly selected pin has to pass the synchroniser before the raw readout
        repeat (4) @(posedge mclk);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk("raw level", lvl, rd[ST_RAW]);
        ev = exp_dp(m, on);
        etr = exp_trig(t, ev, th);
        // a level already logged as 1 only keeps the rise trigger it had; no new 0 to 1 step
        if (t == SILOG_TRIG_RISE && last_bit && !last_trig) begin
            etr = 1'b0;
        end
        wait_dp();
        wait_dp();
        chk("datapoint", ev, dp);
        chk("trigger", etr, tr);
        last_bit = ev[0];
        last_trig = etr;
        apb(1'b0, ADDR_DATA, 32'h0000_0000);
        chk("data register", {16'h0000, ev}, rd);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk("status trigger", etr, rd[ST_TRIG]);
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        closed = 1'b0;
        pin_sel = 1'b0;
        errors = 0;
        samples_checked = 0;
        last_bit = 1'b0;
        last_trig = 1'b0;
        seed = 32'hDDCA03E2;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        apb(1'b0, ADDR_CTRL, 32'h0000_0000);
        chk("ctrl reset", CTRL_RESET, rd);
        apb(1'b0, ADDR_PERIOD, 32'h0000_0000);
        chk("period reset", PERIOD_RESET, rd);
        apb(1'b0, ADDR_THRESH, 32'h0000_0000);
        chk("thresh reset", THRESH_RESET, rd);
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk("unmapped error", 1'b1, err);
        chk("unmapped data", 32'h0000_0000, rd);
        chk("idle claim", 2'h0, pin_claim);
        apb(1'b1, ADDR_PERIOD, {16'h0000, PER});
        for (int k = 0; k < 6; k++) begin
            run(2'(k % 3), k >= 3, 2'(k % 4), k[0] ^ k[1], k[2]);
        end
        for (int k = 0; k < 10; k++) begin
            seed = lfsr(seed);
            run(seed[1:0] == 2'h3 ? 2'h1 : seed[1:0], seed[2], seed[4:3], seed[5], seed[6]);
        end
        tally_and_finish();
    end
endmodule
